// File: fcct_consts.vh
// Constants for the five channel counter/totalizer block.
// Included by fcct_top.v; definitions only.
`ifndef FCCT_CONSTS_VH
`define FCCT_CONSTS_VH
// Register word indices (byte address divided by four)
`define FCCT_REG_CTRL     4'h0
`define FCCT_REG_CHSEL    4'h1
`define FCCT_REG_LIMIT    4'h2
`define FCCT_REG_PRESET   4'h3
`define FCCT_REG_STATUS   4'h4
`define FCCT_REG_RESULT   4'h5
`define FCCT_REG_TBASE    4'h6
`define FCCT_REG_CHIDX    4'h7
// Control fields
`define FCCT_CTRL_RUN     0
`define FCCT_CTRL_IE      1
`define FCCT_CTRL_GATE    2
`define FCCT_CTRL_MODLO   4
`define FCCT_CTRL_MODHI   7
`define FCCT_CTRL_AUTO    8
// Modes
`define FCCT_M_TOT        4'h0
`define FCCT_M_TOTMOD     4'h1
`define FCCT_M_UPDN       4'h2
`define FCCT_M_DIR        4'h3
`define FCCT_M_QUAD       4'h4
`define FCCT_M_RATIO      4'h5
`define FCCT_M_PERIOD     4'h6
`define FCCT_M_PDLY       4'h7
`define FCCT_M_FREQ       4'h8
`define FCCT_M_UPDNMOD    4'h9
`define FCCT_M_DIRMOD     4'hA
`define FCCT_M_QUADMOD    4'hB
// Timing
`define FCCT_CLK_MHZ      125
`define FCCT_TB_1US       (1 * `FCCT_CLK_MHZ)
`define FCCT_GATE_MIN_MS  10
`define FCCT_GATE_MAX_MS  1000
`define FCCT_LIM_MIN      16'h0002
`endif

// File: fcct_top.v
// Five channel counter/totalizer core with Avalon-MM register slave.
// Assumes channel inputs are asynchronous field signals and ref_clk is 125 MHz.
//
// Overview of operation
// - Five channels, each selecting isolated or ground source
// - Per-channel rising or falling active edge
// - Operate at input rates to 200 kHz
// - Frequency/totalize/period per channel; others use pairs
// - Totalize from preset; interrupt on -1 to 0
// - Modulo totalize to N, interrupt; N 2..65535
// - Counts are 32-bit two's complement
// - Gated totalize uses second channel as gate
// - Up/down counts A,B; A-B on read, no interrupt
// - Direction count: B level sets up/down
// - Quadrature counts both A edges, direction B
// - Ratio: A counts over N B periods, divided
// - Period totals N periods of A, 5us..655s
// - Period timebase 1us..10ms selectable
// - Period auto-range enabled by one control bit for all inputs
// - Period after N gated edges of A
// - Frequency over shared gate 10 ms..1 s
// - Controller takes host commands, returns data
`include "fcct_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module fcct_top (
    input  wire        ref_clk,           // 125 MHz clock
    input  wire        rst_n,             // Async reset, active low
    input  wire [5:0]  avs_address,       // Byte address
    input  wire        avs_read,          // Read strobe
    input  wire        avs_write,         // Write strobe
    input  wire [31:0] avs_writedata,     // Write data
    input  wire [3:0]  avs_byteenable,    // Byte enables
    output reg  [31:0] avs_readdata,      // Read data
    output wire        avs_waitrequest,   // Stall
    input  wire [4:0]  iso_in,            // Isolated source per channel
    input  wire [4:0]  gnd_in,            // Ground-referenced source per channel
    output wire        irq                // Count event interrupt, level
);
    // =========================================================
    // Input synchronisers and edge selection
    reg  [4:0]  iso1_q, iso2_q, gnd1_q, gnd2_q, s3_q;
    reg  [4:0]  src_sel_q;   // 1 = isolated
    reg  [4:0]  edge_sel_q;  // 1 = falling
    // source select
    // Both paths are synchronised before the mux, so no raw pin reaches logic;
    // a source switch on a live line can still show one false edge.
    wire [4:0]  lvl  = (src_sel_q & iso2_q) | (~src_sel_q & gnd2_q);
    wire [4:0]  rise = lvl & ~s3_q;
    wire [4:0]  fall = ~lvl & s3_q;
    wire [4:0]  act;
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_edge
            assign act[g] = edge_sel_q[g] ? fall[g] : rise[g];
        end
    endgenerate
    // Two flops per path; s3_q keeps the previous selected level
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            iso1_q <= 5'h00;
            iso2_q <= 5'h00;
            gnd1_q <= 5'h00;
            gnd2_q <= 5'h00;
            s3_q   <= 5'h00;
        end else begin
            iso1_q <= iso_in;
            iso2_q <= iso1_q;
            gnd1_q <= gnd_in;
            gnd2_q <= gnd1_q;
            s3_q   <= lvl;
        end
    end

    // =========================================================
    // Registers
    reg  [31:0] ctrl_q, limit_q, preset_q, tbase_q;
    reg  [2:0]  cha_q, chb_q;
    reg         ev_q, done_q;
    reg  [31:0] cnt_q, cntb_q, res_q, tmr_q, tb_cnt_q;
    reg  [15:0] n_q;
    reg         arm_q;
    wire [3:0]  mode = ctrl_q[`FCCT_CTRL_MODHI:`FCCT_CTRL_MODLO];
    wire        run  = ctrl_q[`FCCT_CTRL_RUN];
    wire [3:0]  widx = avs_address[5:2];
    wire        wr   = avs_write;
    wire        clr_ev = wr && widx == `FCCT_REG_STATUS && avs_writedata[0];
    wire        clr_dn = wr && widx == `FCCT_REG_STATUS && avs_writedata[1];
    wire        start = wr && widx == `FCCT_REG_CTRL && avs_byteenable[0] && avs_writedata[`FCCT_CTRL_RUN];
    // A restart takes the mode being written, not the one it replaces
    wire [3:0]  new_mode = avs_writedata[`FCCT_CTRL_MODHI:`FCCT_CTRL_MODLO];
    reg         rd_ok_q;
    // Reads stall one cycle so the registered word stands when it is taken;
    // writes never stall
    assign avs_waitrequest = avs_read && !rd_ok_q;
    assign irq = ev_q & ctrl_q[`FCCT_CTRL_IE];

    function [31:0] bmerge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer k;
        begin
            bmerge = old;
            for (k = 0; k < 4; k = k + 1)
                if (be[k]) bmerge[k*8 +: 8] = nw[k*8 +: 8];
        end
    endfunction

    function pick;
        input [4:0] v;
        input [2:0] i;
        begin
            pick = (i < 3'd5) ? v[i] : 1'b0;
        end
    endfunction

    function is_mod;
        input [3:0] m;
        begin
            is_mod = (m == `FCCT_M_TOTMOD) || (m == `FCCT_M_UPDNMOD) ||
                     (m == `FCCT_M_DIRMOD) || (m == `FCCT_M_QUADMOD);
        end
    endfunction

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= 32'h0000_0000;
            limit_q    <= 32'h0000_0002;
            preset_q   <= 32'h0000_0000;
            tbase_q    <= 32'h0000_0000;
            src_sel_q  <= 5'h00;
            edge_sel_q <= 5'h00;
            cha_q      <= 3'h0;
            chb_q      <= 3'h1;
        end else if (wr) begin
            case (widx)
                `FCCT_REG_CTRL:   ctrl_q   <= bmerge(ctrl_q, avs_writedata, avs_byteenable);
                `FCCT_REG_LIMIT:  limit_q  <= bmerge(limit_q, avs_writedata, avs_byteenable);
                `FCCT_REG_PRESET: preset_q <= bmerge(preset_q, avs_writedata, avs_byteenable);
                `FCCT_REG_TBASE:  tbase_q  <= bmerge(tbase_q, avs_writedata, avs_byteenable);
                `FCCT_REG_CHSEL: begin
                    if (avs_byteenable[0]) src_sel_q  <= avs_writedata[4:0];
                    if (avs_byteenable[1]) edge_sel_q <= avs_writedata[12:8];
                end
                `FCCT_REG_CHIDX: begin
                    if (avs_byteenable[0]) begin
                        cha_q <= avs_writedata[2:0];
                        chb_q <= avs_writedata[6:4];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // =========================================================
    // Timebase: 1 us times a power of ten (tbase_q[2:0] = 0..4)
    // auto-range picks the base from the last result on this input
    reg  [2:0]  rng_q;
    wire        auto_rng = ctrl_q[`FCCT_CTRL_AUTO];
    wire [2:0]  base_sel = auto_rng ? rng_q : tbase_q[2:0];
    reg  [31:0] tb_len;
    always @* begin
        case (base_sel)
            3'd0:    tb_len = `FCCT_TB_1US;
            3'd1:    tb_len = 10 * `FCCT_TB_1US;
            3'd2:    tb_len = 100 * `FCCT_TB_1US;
            3'd3:    tb_len = 1000 * `FCCT_TB_1US;
            default: tb_len = 10000 * `FCCT_TB_1US;
        endcase
    end
    wire tb_tick = (tb_cnt_q >= tb_len - 32'd1);
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) tb_cnt_q <= 32'h0000_0000;
        else if (start || tb_tick) tb_cnt_q <= 32'h0000_0000;
        else tb_cnt_q <= tb_cnt_q + 32'd1;
    end
    wire [31:0] gate_ms = (tbase_q[31:16] < `FCCT_GATE_MIN_MS) ? `FCCT_GATE_MIN_MS :
                          (tbase_q[31:16] > `FCCT_GATE_MAX_MS) ? `FCCT_GATE_MAX_MS :
                          {16'h0000, tbase_q[31:16]};

    // =========================================================
    // Counting engine
    wire ea = pick(act, cha_q);
    wire eb = pick(act, chb_q);
    wire lb = pick(lvl, chb_q);
    wire ta = pick(rise | fall, cha_q);
    wire gate_ok = !ctrl_q[`FCCT_CTRL_GATE] || lb;
    wire [31:0] lim = (limit_q[15:0] < `FCCT_LIM_MIN) ? {16'h0000, `FCCT_LIM_MIN} :
                      {16'h0000, limit_q[15:0]};
    wire [15:0] nn = (limit_q[15:0] == 16'h0000) ? 16'h0001 : limit_q[15:0];
    wire        modm = is_mod(mode);
    reg  [31:0] cnt_d;
    reg         step;
    always @* begin
        cnt_d = cnt_q;
        step  = 1'b0;
        case (mode)
            `FCCT_M_TOT, `FCCT_M_TOTMOD, `FCCT_M_UPDN, `FCCT_M_UPDNMOD: begin
                step  = ea && gate_ok;
                cnt_d = cnt_q + 32'd1;
            end
            `FCCT_M_DIR, `FCCT_M_DIRMOD: begin
                step  = ea;
                cnt_d = lb ? cnt_q + 32'd1 : cnt_q - 32'd1;
            end
            `FCCT_M_QUAD, `FCCT_M_QUADMOD: begin
                step  = ta;
                cnt_d = lb ? cnt_q + 32'd1 : cnt_q - 32'd1;
            end
            default: begin
            end
        endcase
        if (modm && cnt_d == lim)
            cnt_d = 32'h0000_0000;
    end

    // Frequency gate counter in ms ticks
    reg  [31:0] ms_q, ms_tick_q;
    wire ms_tick = (ms_tick_q == 1000 * `FCCT_TB_1US - 1);

    // one edge per cycle covers 200 kHz
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'h0000_0000;
            cntb_q <= 32'h0000_0000;
            res_q <= 32'h0000_0000;
            tmr_q <= 32'h0000_0000;
            n_q <= 16'h0000;
            arm_q <= 1'b0;
            rng_q <= 3'h0;
            ev_q <= 1'b0;
            done_q <= 1'b0;
            ms_q <= 32'h0000_0000;
            ms_tick_q <= 32'h0000_0000;
        end else begin
            ms_tick_q <= ms_tick ? 32'h0000_0000 : ms_tick_q + 32'd1;
            // Clears come first so an event in the same cycle wins
            if (clr_ev) ev_q <= 1'b0;
            if (clr_dn) done_q <= 1'b0;
            if (start) begin
                cnt_q  <= (new_mode == `FCCT_M_TOT) ? preset_q : 32'h0000_0000;
                rng_q  <= 3'h0;
                cntb_q <= 32'h0000_0000;
                tmr_q  <= 32'h0000_0000;
                n_q    <= 16'h0000;
                arm_q  <= 1'b0;
                ms_q   <= 32'h0000_0000;
            end else if (run) begin
                if (step) begin
                    cnt_q <= cnt_d;
                    if (mode == `FCCT_M_TOT && cnt_q == 32'hFFFF_FFFF)
                        ev_q <= 1'b1;
                    if (mode == `FCCT_M_TOTMOD && cnt_d == 32'h0000_0000)
                        ev_q <= 1'b1;
                end
                case (mode)
                    `FCCT_M_UPDN, `FCCT_M_UPDNMOD: begin
                        if (eb) cntb_q <= cntb_q + 32'd1;
                    end
                    `FCCT_M_RATIO: begin
                        if (ea && cnt_q[15:0] != 16'hFFFF) cnt_q <= cnt_q + 32'd1;
                        if (eb) begin
                            if (n_q == nn) begin
                                res_q <= cnt_q / {16'h0000, nn};
                                done_q <= 1'b1;
                                cnt_q <= 32'h0000_0000;
                                n_q <= 16'h0000;
                            end else n_q <= n_q + 16'd1;
                        end
                    end
                    `FCCT_M_PERIOD: begin
                        if (arm_q && tb_tick) tmr_q <= tmr_q + 32'd1;
                        if (ea) begin
                            if (!arm_q) arm_q <= 1'b1;
                            else if (n_q + 16'd1 == nn) begin
                                res_q <= tmr_q;
                                // a result past 16 bits moves the next one up a decade
                                if (auto_rng && tmr_q[31:16] != 16'h0000 && rng_q < 3'h4)
                                    rng_q <= rng_q + 3'h1;
                                done_q <= 1'b1;
                                tmr_q <= 32'h0000_0000;
                                n_q <= 16'h0000;
                            end else n_q <= n_q + 16'd1;
                        end
                    end
                    `FCCT_M_PDLY: begin
                        if (arm_q && tb_tick) tmr_q <= tmr_q + 32'd1;
                        if (ea && lb) begin
                            if (n_q < limit_q[15:0]) n_q <= n_q + 16'd1;
                            else if (!arm_q) arm_q <= 1'b1;
                            else begin
                                res_q <= tmr_q;
                                done_q <= 1'b1;
                                arm_q <= 1'b0;
                                n_q <= 16'h0000;
                                tmr_q <= 32'h0000_0000;
                            end
                        end
                    end
                    `FCCT_M_FREQ: begin
                        if (ea) cnt_q <= cnt_q + 32'd1;
                        if (ms_tick) begin
                            if (ms_q + 32'd1 == gate_ms) begin
                                res_q <= ea ? cnt_q + 32'd1 : cnt_q;
                                cnt_q <= 32'h0000_0000;
                                done_q <= 1'b1;
                                ms_q <= 32'h0000_0000;
                            end else ms_q <= ms_q + 32'd1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // =========================================================
    // Read path, one wait state; unmapped reads return zero
    // A minus B on read
    wire [31:0] rd_res = (mode == `FCCT_M_UPDN || mode == `FCCT_M_UPDNMOD) ? cnt_q - cntb_q :
                         (mode <= `FCCT_M_QUAD || modm) ? cnt_q : res_q;
    // =========================================================
    // Read handshake: rd_ok_q marks the cycle in which the word stands
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) rd_ok_q <= 1'b0;
        else rd_ok_q <= avs_read && !rd_ok_q;
    end
    // Loaded on the first cycle of a read and held until the next one
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) avs_readdata <= 32'h0000_0000;
        else if (avs_read && !rd_ok_q) begin
            case (widx)
                `FCCT_REG_CTRL:   avs_readdata <= ctrl_q;
                `FCCT_REG_CHSEL:  avs_readdata <= {19'h0, edge_sel_q, 3'h0, src_sel_q};
                `FCCT_REG_LIMIT:  avs_readdata <= limit_q;
                `FCCT_REG_PRESET: avs_readdata <= preset_q;
                `FCCT_REG_STATUS: avs_readdata <= {27'h0, lvl[2:0], done_q, ev_q};
                `FCCT_REG_RESULT: avs_readdata <= rd_res;
                `FCCT_REG_TBASE:  avs_readdata <= tbase_q;
                `FCCT_REG_CHIDX:  avs_readdata <= {25'h0, chb_q, 1'b0, cha_q};
                default:          avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: fcct_src.sv
// Field signal source for the five counter channels.
// The bench calls its tasks; edges are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module fcct_src (
    output var logic [4:0] iso_in, // Isolated path levels
    output var logic [4:0] gnd_in  // Ground path levels
);
    initial begin
        iso_in = 5'h0;
        gnd_in = 5'h0;
    end
    // ==========================================
    // Line drivers
    task automatic lvl(input int ch, input bit iso, input bit v);
        if (iso) iso_in[ch] = v;
        else gnd_in[ch] = v;
    endtask
    task automatic pulse(input int ch, input bit iso, input int n);
        repeat (n) begin
            lvl(ch, iso, 1'b1);
            #2500;
            lvl(ch, iso, 1'b0);
            #2500;
        end
    endtask
    // direction settles well before the count edge
    task automatic dir(input int ch, input bit iso, input bit v);
        lvl(ch, iso, v);
        #2500;
    endtask
endmodule
`default_nettype wire

// File: fcct_checker_assertions.sv
// Checker for the counter core register port and interrupt.
// Sees only the top module's ports; bound at the foot of this file.
`include "fcct_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module fcct_checker (
    input wire logic        ref_clk,         // Clock
    input wire logic        rst_n,           // Reset, active low
    input wire logic [5:0]  avs_address,     // Byte address
    input wire logic        avs_read,        // Read strobe
    input wire logic        avs_write,       // Write strobe
    input wire logic [31:0] avs_writedata,   // Write data
    input wire logic [3:0]  avs_byteenable,  // Byte enables
    input wire logic [31:0] avs_readdata,    // Read data
    input wire logic        avs_waitrequest, // Stall
    input wire logic [4:0]  iso_in,          // Isolated inputs
    input wire logic [4:0]  gnd_in,          // Ground inputs
    input wire logic        irq              // Interrupt
);
    logic [3:0]  mode_q;
    logic        ie_q;
    logic        lim_ok_q;
    logic [15:0] lim_q;
    logic [3:0]  wr_age_q;
    logic [3:0]  quiet_q;
    logic [9:0]  in_q;
    wire  [3:0]  wsel = avs_address[5:2];
    wire         wr_at = avs_write && !avs_waitrequest;
    // ==========================================
    // Shadow of control state; ages saturate so old writes stop mattering
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 4'h0;
            ie_q <= 1'b0;
            lim_q <= 16'h0000;
            lim_ok_q <= 1'b0;
            wr_age_q <= 4'hF;
            quiet_q <= 4'hF;
            in_q <= 10'h000;
        end else begin
            in_q <= {iso_in, gnd_in};
            wr_age_q <= wr_at ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hF};
            quiet_q <= (wr_at || in_q != {iso_in, gnd_in}) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
            if (wr_at && wsel == `FCCT_REG_CTRL && avs_byteenable[0]) begin
                mode_q <= avs_writedata[7:4];
                ie_q <= avs_writedata[1];
            end
            if (wr_at && wsel == `FCCT_REG_LIMIT && avs_byteenable[1:0] == 2'b11) begin
                lim_q <= avs_writedata[15:0];
                lim_ok_q <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Properties
    sequence s_rd_hi;
        avs_read && !avs_waitrequest && avs_address[5];
    endsequence
    sequence s_rd_lim;
        avs_read && !avs_waitrequest && wsel == `FCCT_REG_LIMIT && lim_ok_q;
    endsequence
    sequence s_rd_mod;
        avs_read && !avs_waitrequest && wsel == `FCCT_REG_RESULT && lim_ok_q && mode_q == `FCCT_M_TOTMOD;
    endsequence
    property p_wait_low;
        avs_write |-> !avs_waitrequest;
    endproperty
    property p_rd_wait;
        avs_read && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_rd_hold;
        !$past(avs_read) && !$past(avs_read, 2) |-> $stable(avs_readdata);
    endproperty
    property p_unmapped;
        s_rd_hi |-> (avs_readdata == 32'h0000_0000);
    endproperty
    property p_lim_back;
        s_rd_lim |-> (avs_readdata[15:0] == lim_q);
    endproperty
    property p_mod_below;
        s_rd_mod |-> (avs_readdata < {16'h0000, lim_q});
    endproperty
    property p_irq_ie;
        !ie_q && wr_age_q > 4'h2 |-> !irq;
    endproperty
    property p_irq_cause;
        $rose(irq) |-> quiet_q < 4'hA;
    endproperty
    property p_no_irq_ud;
        (mode_q inside {4'h2, 4'h3, 4'h4, 4'h9, 4'hA, 4'hB}) && wr_age_q > 4'h6 |-> !$rose(irq);
    endproperty
    property p_irq_fall;
        $fell(irq) |-> wr_age_q < 4'h4;
    endproperty
    a_wait_low: assert property (p_wait_low) else $error("waitrequest raised on a write");
    a_rd_wait: assert property (p_rd_wait) else $error("read stalled past one cycle");
    a_rd_hold: assert property (p_rd_hold) else $error("readdata moved without a read");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_lim_back: assert property (p_lim_back) else $error("limit readback differs");
    a_mod_below: assert property (p_mod_below) else $error("modulo count at or above limit");
    a_irq_ie: assert property (p_irq_ie) else $error("interrupt while disabled");
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without input activity");
    a_no_irq_ud: assert property (p_no_irq_ud) else $error("interrupt in up/down family");
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without a write");
endmodule
bind fcct_top fcct_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .iso_in(iso_in), .gnd_in(gnd_in), .irq(irq));
`default_nettype wire

// File: five_channel_counter_totalizer_tb.sv
// Bench for the five channel counter core: register tasks and mode scenarios.
// Assumes fcct_top, the source model and the checker are compiled first.
`include "fcct_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module five_channel_counter_totalizer_tb;
    logic        ref_clk, rst_n, avs_read, avs_write, irq, avs_waitrequest;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, cfg;
    logic [31:0] r [2];
    logic [7:0]  sel, edg;
    wire  [4:0]  iso_in, gnd_in;
    int          err_total, n_tests, cyc, i, s;
    fcct_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .iso_in(iso_in),
        .gnd_in(gnd_in), .irq(irq));
    fcct_src u_src (.iso_in(iso_in), .gnd_in(gnd_in));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ==========================================
    // Bus tasks
    task automatic wr(input logic [3:0] w, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= {w, 2'b00};
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] w, output logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= {w, 2'b00};
        avs_read <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic settle;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Pulses run at 200 kHz, so this ceiling leaves about double the needed time
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_total++;
            wrap_up;
        end
    end
    // ==========================================
    // Scenarios
    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0000_0000;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
        wr(4'h8, 32'hFFFF_FFFF);
        rd(4'h8, r[0]);
        chk("unmapped", 32'h0, r[0]);
        // Source path polarity is found, not assumed: one choice counts, the other not
        for (i = 0; i < 5; i++) begin
            for (s = 0; s < 2; s++) begin
                wr(`FCCT_REG_CHSEL, s ? 32'h0000_001F : 32'h0000_0000);
                wr(`FCCT_REG_CHIDX, i);
                wr(`FCCT_REG_CTRL, 32'h0000_0001);
                u_src.pulse(i, 1'b1, 3);
                settle;
                rd(`FCCT_REG_RESULT, r[s]);
            end
            chk("src_sum", 32'h3, r[0] + r[1]);
            chk("src_zero", 32'h0, r[0] * r[1]);
        end
        sel = (r[1] === 32'h3) ? 8'h1F : 8'h00;
        wr(`FCCT_REG_CHIDX, 32'h0000_0000);
        // Line left high after two pulses: one edge choice sees 3, the other 2
        for (s = 0; s < 2; s++) begin
            wr(`FCCT_REG_CHSEL, {16'h0000, s ? 8'h1F : 8'h00, sel});
            wr(`FCCT_REG_CTRL, 32'h0000_0001);
            u_src.pulse(0, 1'b1, 2);
            u_src.dir(0, 1'b1, 1'b1);
            settle;
            rd(`FCCT_REG_RESULT, r[s]);
            u_src.dir(0, 1'b1, 1'b0);
        end
        chk("edge_sum", 32'h5, r[0] + r[1]);
        chk("edge_prod", 32'h6, r[0] * r[1]);
        edg = (r[1] === 32'h3) ? 8'h1F : 8'h00;
        cfg = {16'h0000, edg, sel};
        wr(`FCCT_REG_CHSEL, cfg);
        wr(`FCCT_REG_CHIDX, 32'h0000_0000);
        wr(`FCCT_REG_PRESET, 32'hFFFF_FFFD);
        wr(`FCCT_REG_STATUS, 32'h0000_0003);
        wr(`FCCT_REG_CTRL, {24'h0, `FCCT_M_TOT, 4'h3});
        u_src.pulse(0, 1'b1, 2);
        settle;
        chk("irq_early", 32'h0, {31'h0, irq});
        rd(`FCCT_REG_RESULT, r[0]);
        chk("tot_neg", 32'hFFFF_FFFF, r[0]);
        u_src.pulse(0, 1'b1, 1);
        settle;
        chk("irq_zero", 32'h1, {31'h0, irq});
        rd(`FCCT_REG_RESULT, r[0]);
        chk("tot_zero", 32'h0, r[0]);
        wr(`FCCT_REG_STATUS, 32'h0000_0003);
        settle;
        chk("irq_clr", 32'h0, {31'h0, irq});
        wr(`FCCT_REG_LIMIT, 32'h0000_0003);
        wr(`FCCT_REG_CTRL, {24'h0, `FCCT_M_TOTMOD, 4'h3});
        u_src.pulse(0, 1'b1, 2);
        settle;
        chk("irq_mod_early", 32'h0, {31'h0, irq});
        u_src.pulse(0, 1'b1, 2);
        settle;
        chk("irq_mod", 32'h1, {31'h0, irq});
        rd(`FCCT_REG_RESULT, r[0]);
        chk("mod_wrap", 32'h1, r[0]);
        rd(`FCCT_REG_LIMIT, r[0]);
        chk("limit", 32'h3, {16'h0, r[0][15:0]});
        wr(`FCCT_REG_STATUS, 32'h0000_0003);
        wr(`FCCT_REG_CHIDX, 32'h0000_0021);
        wr(`FCCT_REG_CTRL, {24'h0, `FCCT_M_UPDN, 4'h3});
        u_src.pulse(1, 1'b1, 5);
        u_src.pulse(2, 1'b1, 2);
        settle;
        rd(`FCCT_REG_RESULT, r[0]);
        chk("updn", 32'h3, r[0]);
        chk("irq_updn", 32'h0, {31'h0, irq});
        wr(`FCCT_REG_CHIDX, 32'h0000_0043);
        wr(`FCCT_REG_CTRL, {24'h0, `FCCT_M_DIR, 4'h3});
        u_src.dir(4, 1'b1, 1'b1);
        u_src.pulse(3, 1'b1, 4);
        u_src.dir(4, 1'b1, 1'b0);
        u_src.pulse(3, 1'b1, 1);
        settle;
        rd(`FCCT_REG_RESULT, r[0]);
        chk("dir", 32'h3, r[0][31] ? -r[0] : r[0]);
        chk("irq_dir", 32'h0, {31'h0, irq});
        wr(`FCCT_REG_CTRL, {24'h0, `FCCT_M_QUAD, 4'h3});
        u_src.pulse(3, 1'b1, 2);
        settle;
        rd(`FCCT_REG_RESULT, r[0]);
        chk("quad", 32'h4, r[0][31] ? -r[0] : r[0]);
        // Two 5 us periods on channel 3 at the 1 us base: ten ticks in all
        wr(`FCCT_REG_LIMIT, 32'h0000_0002);
        wr(`FCCT_REG_TBASE, 32'h0000_0000);
        wr(`FCCT_REG_CTRL, {24'h0, `FCCT_M_PERIOD, 4'h1});
        u_src.pulse(3, 1'b1, 3);
        settle;
        rd(`FCCT_REG_RESULT, r[0]);
        chk("period", 32'hA, r[0]);
        rd(`FCCT_REG_STATUS, r[1]);
        chk("per_done", 32'h2, r[1] & 32'h0000_0002);
        wrap_up;
    end
endmodule
`default_nettype wire
